// [hw/csd_pkg.sv]
// Constants for the chip-select area decoder: register map, fields,
// reset values and area layout.
// Assumes a 16-bit register port and a 24-bit internal bus address.
// Summary of operation
// - Four programmable areas plus other space, each with width and waits.
// - Each bus cycle compares address; matching area selects, sets timing.
// - Select reaches the pin only when its port 6 function bit is set.
// - Start register holds A23..A16; low sixteen start bits are zero.
// - Mask bit one removes that address bit from the comparison.
// - Areas 0 and 1 masks cover different address bits; areas 2 and 3 share one set.
// - Area 0 mask covers A20..A8, loaded with end minus start.
// - Reset loads all start registers with all ones, mask registers with their writable bits set.
// - After reset only area 2 is enabled, in whole-space mode.
// - Addresses outside all areas use the other-area width and waits.
// - Lowest-numbered matching area wins; only its select asserts.
// - Active-low wait request is the only external cycle-length control.
// - Wait codes: 000 two, 001 one, 010 one plus extend, 011 zero.
// - Bit 3 selects 16-bit bus when zero, 8-bit bus when one.
// - Bit 7 of each area control register is the area master enable.
// - Area 2 range select zero gives whole space, one uses registers.
package csd_pkg;
  localparam int NUM_AREAS = 4;
  localparam logic [7:0] REG_START0  = 8'h00;
  localparam logic [7:0] REG_MASK0   = 8'h04;
  localparam logic [7:0] REG_CTRL0   = 8'h08;
  localparam logic [7:0] REG_OTHER   = 8'h0c;
  localparam logic [7:0] REG_P6FN    = 8'h0d;
  localparam logic [7:0] REG_P6DATA  = 8'h0e;
  localparam logic [7:0] REG_STATUS  = 8'h0f;
  // Control register fields
  localparam int CTRL_EN    = 7;
  localparam int CTRL_RANGE = 6;
  localparam int CTRL_BUS8  = 3;
  localparam logic [7:0] CTRL_RESET  = 8'h00;
  localparam logic [7:0] CTRL2_RESET = 8'h80;
  localparam logic [3:0] OTHER_RESET = 4'h0;
  localparam logic [3:0] P6FN_RESET  = 4'h0;
  localparam logic [3:0] P6DATA_RESET = 4'hb;
  localparam logic [7:0] START_RESET = 8'hff;
  // Mask bit i covers address bit i+8; writable bits per area
  localparam logic [15:0] MASK_W0 = 16'h1fff;
  localparam logic [15:0] MASK_W1 = 16'h3fff;
  localparam logic [15:0] MASK_W23 = 16'h7f80;
  // Address bits always ignored below an area's smallest size
  localparam logic [15:0] LOW_IGN01 = 16'h0000;
  localparam logic [15:0] LOW_IGN23 = 16'h007f;
  localparam logic [7:0]  START_LOW = 8'h00;
  // Area 2 whole-space mode
  localparam logic [23:0] WHOLE_LO_START = 24'h003000;
  localparam logic [23:0] WHOLE_LO_END   = 24'h01f7ff;
  localparam logic [23:0] WHOLE_HI_START = 24'h020000;
  // Wait codes
  localparam logic [2:0] WAIT_TWO  = 3'b000;
  localparam logic [2:0] WAIT_ONE  = 3'b001;
  localparam logic [2:0] WAIT_EXT  = 3'b010;
  localparam logic [2:0] WAIT_ZERO = 3'b011;
  localparam logic [1:0] CNT_TWO  = 2'd2;
  localparam logic [1:0] CNT_ONE  = 2'd1;
  localparam logic [1:0] CNT_ZERO = 2'd0;
  localparam logic [2:0] AREA_OTHER = 3'd4;
  typedef enum logic [0:0] {
    ST_IDLE   = 1'b0,
    ST_ACCESS = 1'b1
  } csd_state_t;
endpackage

// [hw/csd_area_decoder.sv]
// Chip-select area decoder: four programmable areas, priority choice,
// wait-state sequencing and port 6 pin multiplexing.
// Assumes the CPU raises busStart for one cycle while busReady is high and
// holds busAddr stable in that cycle; waitReq_n comes from outside.
//
// The implementer's own choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
module csd_area_decoder
(
  // Clock, reset, enable
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        ce,
  // Register port
  input  wire logic [7:0]  regAddr,
  input  wire logic [15:0] regWdata,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic [15:0]      regRdata,
  // CPU bus side
  input  wire logic        busStart,
  input  wire logic [23:0] busAddr,
  output logic             busReady,
  output logic             busDone,
  output logic             busWidth8,
  output logic [2:0]       busArea,
  // External memory side
  input  wire logic        waitReq_n,
  output logic             area0_select_n,
  output logic             area1_select_n,
  output logic             area2_select_n,
  output logic             area3_select_n
);

  logic [7:0]  startBase [csd_pkg::NUM_AREAS];
  logic [15:0] sizeMask  [csd_pkg::NUM_AREAS];
  logic [7:0]  busCtrl   [csd_pkg::NUM_AREAS];
  logic [3:0]  otherCtrl;
  logic [3:0]  port6Fn;
  logic [3:0]  port6Data;
  logic [3:0]  hit;
  logic [3:0]  csActive;
  logic [3:0]  areaEnable;
  csd_pkg::csd_state_t state;
  logic [1:0]  waitCnt;
  logic        extendMode;
  logic        waitS1;
  logic        waitS2;
  logic        waitS3;
  logic        waitLow;

  // Per-area registers, decoding and hit flags
  genvar k;
  generate
    for (k = 0; k < csd_pkg::NUM_AREAS; k++)
    begin : g_area
      localparam logic [15:0] WMASK = (k == 0) ? csd_pkg::MASK_W0 :
                                      (k == 1) ? csd_pkg::MASK_W1 :
                                      csd_pkg::MASK_W23;
      localparam logic [15:0] LOWIGN = (k < 2) ? csd_pkg::LOW_IGN01 :
                                       csd_pkg::LOW_IGN23;
      localparam logic [7:0] CTRLRST = (k == 2) ? csd_pkg::CTRL2_RESET :
                                       csd_pkg::CTRL_RESET;
      wire wrStart = regWr && regAddr == csd_pkg::REG_START0 + 8'(k);
      wire wrMask  = regWr && regAddr == csd_pkg::REG_MASK0 + 8'(k);
      wire wrCtrl  = regWr && regAddr == csd_pkg::REG_CTRL0 + 8'(k);
      wire [15:0] expected = {startBase[k], csd_pkg::START_LOW};
      wire [15:0] ignore   = (sizeMask[k] & WMASK) | LOWIGN;
      wire regMatch = &((busAddr[23:8] ~^ expected) | ignore);
      wire wholeHit = (busAddr >= csd_pkg::WHOLE_LO_START &&
                       busAddr <= csd_pkg::WHOLE_LO_END) ||
                      busAddr >= csd_pkg::WHOLE_HI_START;
      wire useWhole = (k == 2) && !busCtrl[k][csd_pkg::CTRL_RANGE];
      assign areaEnable[k] = busCtrl[k][csd_pkg::CTRL_EN];
      assign hit[k] = areaEnable[k] && (useWhole ? wholeHit : regMatch);

      always_ff @(posedge clk or negedge arst_n)
      begin
        if (!arst_n)
        begin
          startBase[k] <= csd_pkg::START_RESET;
          sizeMask[k]  <= WMASK;
          busCtrl[k]   <= CTRLRST;
        end
        else if (ce)
        begin
          if (wrStart)
            startBase[k] <= regWdata[7:0];
          if (wrMask)
            sizeMask[k] <= regWdata & WMASK;
          if (wrCtrl)
            busCtrl[k] <= regWdata[7:0];
        end
      end
    end
  endgenerate

  // Pins follow the port latch unless the function bit picks select use
  assign area0_select_n = port6Fn[0] ? !csActive[0] : port6Data[0];
  assign area1_select_n = port6Fn[1] ? !csActive[1] : port6Data[1];
  assign area2_select_n = port6Fn[2] ? !csActive[2] : port6Data[2];
  assign area3_select_n = port6Fn[3] ? !csActive[3] : port6Data[3];

  // Lowest-numbered hit wins
  wire [2:0] chosenArea = hit[0] ? 3'd0 : hit[1] ? 3'd1 :
                          hit[2] ? 3'd2 : hit[3] ? 3'd3 :
                          csd_pkg::AREA_OTHER;
  wire [3:0] chosenOneHot = hit & ~(hit << 1) & ~(hit << 2) & ~(hit << 3);
  wire [3:0] otherFull = otherCtrl;
  wire [3:0] chosenCfg = (chosenArea == csd_pkg::AREA_OTHER) ? otherFull :
                         busCtrl[chosenArea[1:0]][3:0];
  wire [2:0] chosenWait = chosenCfg[2:0];
  wire chosenBus8 = chosenCfg[csd_pkg::CTRL_BUS8];
  // Reserved codes 1xx fall back to the safest setting, two waits
  wire [1:0] chosenCnt =
    (chosenWait == csd_pkg::WAIT_ZERO) ? csd_pkg::CNT_ZERO :
    (chosenWait == csd_pkg::WAIT_ONE ||
     chosenWait == csd_pkg::WAIT_EXT) ? csd_pkg::CNT_ONE :
    csd_pkg::CNT_TWO;
  wire startTaken = busStart && busReady;

  assign busReady = state == csd_pkg::ST_IDLE;
  assign busDone = state == csd_pkg::ST_ACCESS &&
                   waitCnt == csd_pkg::CNT_ZERO &&
                   !(extendMode && waitLow);

  // Wait request passes three flops; a change counts once two agree
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      waitS1  <= 1'b1;
      waitS2  <= 1'b1;
      waitS3  <= 1'b1;
      waitLow <= 1'b0;
    end
    else if (ce)
    begin
      waitS1 <= waitReq_n;
      waitS2 <= waitS1;
      waitS3 <= waitS2;
      if (waitS2 == waitS3)
        waitLow <= !waitS3;
    end
  end

  // Bus cycle sequencer
  csd_pkg::csd_state_t next_state;
  assign next_state = startTaken ? csd_pkg::ST_ACCESS :
                      busDone ? csd_pkg::ST_IDLE : state;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state      <= csd_pkg::ST_IDLE;
      waitCnt    <= csd_pkg::CNT_ZERO;
      extendMode <= 1'b0;
      csActive   <= 4'h0;
      busWidth8  <= 1'b0;
      busArea    <= csd_pkg::AREA_OTHER;
    end
    else if (ce)
    begin
      state <= next_state;
      if (startTaken)
      begin
        waitCnt    <= chosenCnt;
        extendMode <= chosenWait == csd_pkg::WAIT_EXT;
        csActive   <= chosenOneHot;
        busWidth8  <= chosenBus8;
        busArea    <= chosenArea;
      end
      else if (busDone)
        csActive <= 4'h0;
      else if (waitCnt != csd_pkg::CNT_ZERO)
        waitCnt <= waitCnt - 2'd1;
    end
  end

  // Shared registers
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      otherCtrl <= csd_pkg::OTHER_RESET;
      port6Fn   <= csd_pkg::P6FN_RESET;
      port6Data <= csd_pkg::P6DATA_RESET;
    end
    else if (ce && regWr)
    begin
      if (regAddr == csd_pkg::REG_OTHER)
        otherCtrl <= regWdata[3:0];
      if (regAddr == csd_pkg::REG_P6FN)
        port6Fn <= regWdata[3:0];
      if (regAddr == csd_pkg::REG_P6DATA)
        port6Data <= regWdata[3:0];
    end
  end

  // Read path; unmapped addresses read zero
  logic [15:0] readMux;
  wire  [15:0] statusWord = {7'h00, busWidth8, csActive, busArea,
                             state == csd_pkg::ST_ACCESS};
  always_comb
  begin
    readMux = 16'h0000;
    if (regAddr < csd_pkg::REG_MASK0)
      readMux = {8'h00, startBase[regAddr[1:0]]};
    else if (regAddr < csd_pkg::REG_CTRL0)
      readMux = sizeMask[regAddr[1:0]];
    else if (regAddr < csd_pkg::REG_OTHER)
      readMux = {8'h00, busCtrl[regAddr[1:0]]};
    else if (regAddr == csd_pkg::REG_OTHER)
      readMux = {12'h000, otherCtrl};
    else if (regAddr == csd_pkg::REG_P6FN)
      readMux = {12'h000, port6Fn};
    else if (regAddr == csd_pkg::REG_P6DATA)
      readMux = {12'h000, port6Data};
    else if (regAddr == csd_pkg::REG_STATUS)
      readMux = statusWord;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      regRdata <= 16'h0000;
    else if (ce && regRd)
      regRdata <= readMux;
  end

  // Checks
  property p_one_select;
    @(posedge clk) disable iff (!arst_n)
    $onehot0(csActive);
  endproperty
  a_one_select: assert property (p_one_select)
    else $error("more than one area select active");

  property p_priority;
    @(posedge clk) disable iff (!arst_n)
    (ce && startTaken && hit[0]) |=> csActive == 4'h1 && busArea == 3'd0;
  endproperty
  a_priority: assert property (p_priority)
    else $error("area 0 hit did not win");

  property p_disabled;
    @(posedge clk) disable iff (!arst_n)
    (ce && startTaken && !areaEnable[1]) |=> !csActive[1];
  endproperty
  a_disabled: assert property (p_disabled)
    else $error("disabled area 1 selected");

  property p_other;
    @(posedge clk) disable iff (!arst_n)
    (ce && startTaken && hit == 4'h0) |=>
      csActive == 4'h0 && busArea == csd_pkg::AREA_OTHER &&
      busWidth8 == $past(otherCtrl[3]);
  endproperty
  a_other: assert property (p_other)
    else $error("unmatched access not using other-area settings");

  property p_zero_wait;
    @(posedge clk) disable iff (!arst_n)
    (ce && startTaken && chosenWait == csd_pkg::WAIT_ZERO) |=> busDone;
  endproperty
  a_zero_wait: assert property (p_zero_wait)
    else $error("zero-wait cycle not done in one cycle");

  property p_two_wait;
    @(posedge clk) disable iff (!arst_n)
    (ce && startTaken && chosenWait == csd_pkg::WAIT_TWO) ##1 ce[*3] |->
      !$past(busDone, 2) && !$past(busDone) && busDone;
  endproperty
  a_two_wait: assert property (p_two_wait)
    else $error("two-wait cycle length wrong");

  property p_one_wait;
    @(posedge clk) disable iff (!arst_n)
    (ce && startTaken && chosenWait == csd_pkg::WAIT_ONE) ##1 ce[*2] |->
      !$past(busDone) && busDone;
  endproperty
  a_one_wait: assert property (p_one_wait)
    else $error("one-wait cycle length wrong");

  property p_ext_first;
    @(posedge clk) disable iff (!arst_n)
    (ce && startTaken && chosenWait == csd_pkg::WAIT_EXT) |=> !busDone;
  endproperty
  a_ext_first: assert property (p_ext_first)
    else $error("extendable cycle skipped its fixed wait");

  property p_width;
    @(posedge clk) disable iff (!arst_n)
    (ce && startTaken && hit[0]) |=>
      busWidth8 == $past(busCtrl[0][csd_pkg::CTRL_BUS8]);
  endproperty
  a_width: assert property (p_width)
    else $error("area 0 cycle not using area 0 bus width");

  // Written as xor-and-mask so it does not mirror the decoder's form
  property p_match;
    @(posedge clk) disable iff (!arst_n)
    (ce && startTaken && areaEnable[0] &&
     ((busAddr[23:8] ^ {startBase[0], csd_pkg::START_LOW}) &
      ~sizeMask[0]) == 16'h0000) |=> csActive[0];
  endproperty
  a_match: assert property (p_match)
    else $error("area 0 address match missed");

  property p_pin_select;
    @(posedge clk) disable iff (!arst_n)
    (state == csd_pkg::ST_ACCESS && busArea == 3'd1 && port6Fn[1]) |->
      !area1_select_n;
  endproperty
  a_pin_select: assert property (p_pin_select)
    else $error("area 1 pin high during its cycle");

  property p_release;
    @(posedge clk) disable iff (!arst_n)
    (ce && busDone) |=> busReady && csActive == 4'h0;
  endproperty
  a_release: assert property (p_release)
    else $error("select or busy held after cycle end");

  property p_hold_select;
    @(posedge clk) disable iff (!arst_n)
    (ce && csActive[2] && !busDone) |=> csActive[2];
  endproperty
  a_hold_select: assert property (p_hold_select)
    else $error("area 2 select dropped before cycle end");

  property p_extend;
    @(posedge clk) disable iff (!arst_n)
    (state == csd_pkg::ST_ACCESS && extendMode && waitLow) |-> !busDone;
  endproperty
  a_extend: assert property (p_extend)
    else $error("cycle ended while wait request low");

  property p_pin_port;
    @(posedge clk) disable iff (!arst_n)
    (!port6Fn[0] ##1 !port6Fn[0]) |-> area0_select_n == port6Data[0];
  endproperty
  a_pin_port: assert property (p_pin_port)
    else $error("pin left port control");

  property p_whole;
    @(posedge clk) disable iff (!arst_n)
    (ce && startTaken && hit[1:0] == 2'b00 && areaEnable[2] &&
     !busCtrl[2][csd_pkg::CTRL_RANGE] &&
     busAddr >= csd_pkg::WHOLE_HI_START) |=> csActive[2];
  endproperty
  a_whole: assert property (p_whole)
    else $error("whole-space area 2 missed");

endmodule

// [verification/csd_mem_model.sv]
// External memory model: a slow device that holds the wait request low.
// Assumes the bench pulses kick for one cycle with stallLen already valid.
`timescale 1ns/1ps
module csd_mem_model
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       arst_n,
  // Control from the bench
  input  wire logic       kick,
  input  wire logic [7:0] stallLen,
  // Memory side
  output logic            waitReq_n
);
  logic [7:0] busyLeft;

  // Busy for stallLen cycles after a kick; idle level is high
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
      busyLeft <= 8'h00;
    else if (kick)
      busyLeft <= stallLen;
    else if (busyLeft != 8'h00)
      busyLeft <= busyLeft - 8'h01;

  assign waitReq_n = (busyLeft == 8'h00);
endmodule

// [verification/chip_select_area_decoder_tb.sv]
// Self-checking bench for the area decoder with a slow memory model.
// Assumes the decoder's register map and timing as handed over.
`timescale 1ns/1ps
module chip_select_area_decoder_tb;
  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic [7:0]  regAddr = 8'h00;
  logic [15:0] regWdata = 16'h0000;
  logic        regWr = 1'b0;
  logic        regRd = 1'b0;
  logic [15:0] regRdata;
  logic        busStart = 1'b0;
  logic [23:0] busAddr = 24'h000000;
  logic        busReady;
  logic        busDone;
  logic        busWidth8;
  logic [2:0]  busArea;
  logic        waitReq_n;
  logic        kick = 1'b0;
  logic [7:0]  stallLen = 8'h0c;
  logic [3:0]  sel_n;
  logic [3:0]  fnBits = 4'h0;
  logic [3:0]  pd = csd_pkg::P6DATA_RESET;
  logic        ce = 1'b1;
  logic [3:0]  oth = 4'h0;
  logic [7:0]  st [4];
  logic [15:0] mk [4];
  logic [7:0]  ct [4];
  logic [31:0] rnd = 32'h8079;
  int          miscompares = 0;
  int          testsRun = 0;

  csd_area_decoder DUT (.clk(clk), .arst_n(arst_n), .ce(ce),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .busStart(busStart), .busAddr(busAddr),
    .busReady(busReady), .busDone(busDone), .busWidth8(busWidth8),
    .busArea(busArea), .waitReq_n(waitReq_n), .area0_select_n(sel_n[0]),
    .area1_select_n(sel_n[1]), .area2_select_n(sel_n[2]),
    .area3_select_n(sel_n[3]));
  csd_mem_model MEM (.clk(clk), .arst_n(arst_n), .kick(kick),
    .stallLen(stallLen), .waitReq_n(waitReq_n));

  always #5 clk = ~clk;

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c11db7 : 32'h0);
  endfunction
  function automatic logic [15:0] wmask(input int k);
    return k == 0 ? 16'h1fff : (k == 1 ? 16'h3fff : 16'h7f80);
  endfunction
  // Lowest enabled matching area wins; the rest falls to other space
  function automatic logic [2:0] expArea(input logic [23:0] a);
    logic [15:0] dif;
    for (int k = 0; k < 4; k++)
    begin
      dif = (a[23:8] ^ {st[k], 8'h00}) & ~(mk[k] | (k < 2 ? 16'h0 : 16'h7f));
      if (ct[k][7] && k == 2 && !ct[k][6])
      begin
        if ((a >= 24'h003000 && a <= 24'h01f7ff) || a >= 24'h020000)
          return 3'd2;
      end
      else if (ct[k][7] && dif == 16'h0000)
        return 3'(k);
    end
    return 3'd4;
  endfunction
  function automatic logic [3:0] selExp(input logic [2:0] ea);
    for (int k = 0; k < 4; k++)
      selExp[k] = fnBits[k] ? (ea != 3'(k)) : pd[k];
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string m);
    testsRun++;
    if (got !== exp)
    begin
      miscompares++;
      $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic closeOut;
    $display("Counts: %0d compares, %0d mismatches", testsRun, miscompares);
    if (miscompares == 0 && testsRun > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk);
    regWr <= 1'b0;
    // A write taken while the clock enable is low must not land
    if (!ce)
      return;
    if (a < 8'h04)
      st[a[1:0]] = d[7:0];
    else if (a < 8'h08)
      mk[a[1:0]] = d & wmask(a[1:0]);
    else if (a < 8'h0c)
      ct[a[1:0]] = d[7:0];
    else if (a == csd_pkg::REG_OTHER)
      oth = d[3:0];
    else if (a == csd_pkg::REG_P6FN)
      fnBits = d[3:0];
    else if (a == csd_pkg::REG_P6DATA)
      pd = d[3:0];
  endtask
  task automatic rdChk(input logic [7:0] a, input logic [15:0] e);
    @(posedge clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    @(negedge clk);
    chk({16'h0, regRdata}, {16'h0, e}, "register read");
  endtask
  // One bus cycle; a stall kicks the slow memory a few cycles ahead
  task automatic cyc(input logic [23:0] a, input logic stall);
    logic [2:0] ea;
    logic [2:0] code;
    int n;
    ea = expArea(a);
    code = (ea < 3'd4) ? ct[ea][2:0] : oth[2:0];
    if (stall)
    begin
      @(posedge clk);
      kick <= 1'b1;
      @(posedge clk);
      kick <= 1'b0;
      repeat (5) @(posedge clk);
    end
    @(posedge clk);
    busStart <= 1'b1;
    busAddr <= a;
    @(posedge clk);
    busStart <= 1'b0;
    for (n = 1; n < 40; n++)
    begin
      @(negedge clk);
      chk({28'h0, sel_n}, {28'h0, selExp(ea)}, "select pins");
      chk({31'h0, busReady}, 32'h0, "ready during cycle");
      if (busDone === 1'b1)
        break;
    end
    if (n == 40)
    begin
      miscompares++;
      closeOut();
    end
    chk({29'h0, busArea}, {29'h0, ea}, "area");
    chk({31'h0, busWidth8}, (ea < 3'd4) ? ct[ea][3] : oth[3], "width");
    if (code == csd_pkg::WAIT_EXT && stall)
      chk(n > 2 && n < 24, 1, "extended cycle");
    else
      chk(n, code == 3'b011 ? 1 : (code[2:1] == 2'b00 || code == 3'b010)
             ? 3 - code[0] - code[1] : 3, "cycle length");
    // Let the filtered wait request go idle, or the next cycle stretches
    if (stall)
      repeat (12) @(posedge clk);
  endtask

  initial
  begin
    logic [23:0] a;
    logic [23:0] pts [6];
    pts = '{24'h003000, 24'h002fff, 24'h01f7ff, 24'h01f800,
            24'h020000, 24'hffffff};
    for (int k = 0; k < 4; k++)
    begin
      st[k] = 8'hff;
      mk[k] = wmask(k);
      ct[k] = (k == 2) ? 8'h80 : 8'h00;
    end
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    for (int k = 0; k < 4; k++)
    begin
      rdChk(8'(k), 16'h00ff);
      rdChk(8'(k + 4), wmask(k));
      rdChk(8'(k + 8), {8'h0, ct[k]});
    end
    rdChk(csd_pkg::REG_P6DATA, {12'h000, csd_pkg::P6DATA_RESET});
    rdChk(csd_pkg::REG_STATUS, 16'h0008);
    wr(8'h40, 16'hffff);
    rdChk(8'h40, 16'h0000);
    @(posedge clk);
    ce <= 1'b0;
    wr(8'h03, 16'h0012);
    ce <= 1'b1;
    rdChk(8'h03, {8'h00, st[3]});
    $display("test reset values done");
    wr(csd_pkg::REG_P6FN, 16'h000f);
    wr(csd_pkg::REG_OTHER, 16'h0009);
    foreach (pts[i])
      cyc(pts[i], 1'b0);
    $display("test whole space done");
    wr(8'h00, 16'h0001);
    wr(8'h04, 16'h00ff);
    wr(8'h01, 16'h0001);
    wr(8'h05, 16'h01ff);
    wr(8'h09, 16'h0081);
    for (int c = 0; c < 4; c++)
    begin
      wr(8'h08, 16'(8'h88 | c));
      cyc(24'h01abcd, 1'b0);
      cyc(24'h01abcd, 1'b1);
    end
    wr(8'h08, 16'h000b);
    cyc(24'h01abcd, 1'b0);
    wr(8'h0a, 16'h00c2);
    wr(8'h02, 16'h0090);
    wr(8'h03, 16'h0080);
    wr(8'h07, 16'h0080);
    wr(8'h0b, 16'h0082);
    wr(csd_pkg::REG_P6FN, 16'h0007);
    wr(csd_pkg::REG_P6DATA, 16'h0006);
    cyc(24'h80f123, 1'b1);
    $display("test areas done");
    for (int i = 0; i < 300; i++)
    begin
      rnd = lfsr(rnd);
      if (i % 50 == 0)
      begin
        wr(8'h01, {8'h00, rnd[7:0]});
        wr(8'h05, rnd[31:16]);
        wr(8'h09, {8'h00, rnd[8], 3'b000, rnd[9], 1'b0, rnd[11:10]});
        wr(csd_pkg::REG_P6FN, {12'h000, rnd[15:12]});
        wr(csd_pkg::REG_P6DATA, {12'h000, rnd[7:4]});
        rnd = lfsr(rnd);
      end
      a = {rnd[18] ? rnd[31:24] : st[rnd[17:16]], rnd[15:0]};
      cyc(a, rnd[22] & rnd[21]);
    end
    $display("test random done");
    closeOut();
  end
endmodule
